// ### shared/ppde_consts.vh
// constants for the port pin direction enable block
`ifndef PPDE_CONSTS_VH
`define PPDE_CONSTS_VH

// register indexes; byte address is four times the index
`define PPDE_IDX_A_IE 16'h30b8
`define PPDE_IDX_B_IE 16'h30b9
`define PPDE_IDX_C_OE 16'h30b2
`define PPDE_IDX_C_DATA 16'h30c0
`define PPDE_IDX_A_LEVEL 16'h30c1
`define PPDE_IDX_B_LEVEL 16'h30c2

// writable bit masks
`define PPDE_A_IE_MASK 8'h2f
`define PPDE_B_IE_MASK 8'hff
`define PPDE_C_OE_MASK 8'h0f

// reset values
`define PPDE_RST_BYTE 8'h00
`define PPDE_RST_WORD 32'h0000_0000

// ahb-lite encodings
`define PPDE_HTRANS_NONSEQ_BIT 1
`define PPDE_HRESP_OKAY 1'b0
`define PPDE_IDX_LSB 2
`define PPDE_IDX_MSB 17

`endif

// ### hw/ppde_pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module ppde_pin_sync #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    // asynchronous pin levels
    input wire [WIDTH-1:0] pin_async,
    // filtered level, changes only when stages two and three agree
    output reg [WIDTH-1:0] level_reg
);

reg [WIDTH-1:0] s1_reg;
reg [WIDTH-1:0] s2_reg;
reg [WIDTH-1:0] s3_reg;
integer i;

// s1 feeds only s2, so metastability never reaches the compare
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        s1_reg <= {WIDTH{1'b0}};
        s2_reg <= {WIDTH{1'b0}};
        s3_reg <= {WIDTH{1'b0}};
        level_reg <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
        s1_reg <= pin_async;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        for (i = 0; i < WIDTH; i = i + 1)
        begin
            if (s2_reg[i] == s3_reg[i])
                level_reg[i] <= s3_reg[i];
        end
    end
end

endmodule

// ### hw/ppde_top.v
// port pin direction enable bank with ahb-lite register slave
`timescale 1ns/1ns
`include "ppde_consts.vh"
module ppde_top #(
    parameter A_W = 8,
    parameter B_W = 8,
    parameter C_W = 4
) (
    // clock, reset, clock enable
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // first port pins, input only
    input wire [A_W-1:0] first_port_pin_in,
    output reg [A_W-1:0] first_port_input_enable,
    output reg [A_W-1:0] first_port_level,
    // second port pins, input only
    input wire [B_W-1:0] second_port_pin_in,
    output reg [B_W-1:0] second_port_input_enable,
    output reg [B_W-1:0] second_port_level,
    // third port pins, two-way
    input wire [C_W-1:0] third_port_pin_in,
    output reg [C_W-1:0] third_port_pin_out,
    output reg [C_W-1:0] third_port_pin_oe_n,
    output reg [C_W-1:0] third_port_drive_enable,
    output reg [C_W-1:0] third_port_level
);

// one-hot register selects held for the data phase
localparam SEL_NONE = 7'b0000001;
localparam SEL_A_IE = 7'b0000010;
localparam SEL_B_IE = 7'b0000100;
localparam SEL_C_OE = 7'b0001000;
localparam SEL_C_DATA = 7'b0010000;
localparam SEL_A_LEVEL = 7'b0100000;
localparam SEL_B_LEVEL = 7'b1000000;

// address phase bookkeeping
reg [6:0] dp_sel_reg;
reg dp_write_reg;
reg [6:0] ap_sel;
wire ap_take;
wire [15:0] ap_idx;
wire ap_in_range;

// register state and next values
reg [7:0] a_ie_reg;
reg [7:0] a_ie_next;
reg [7:0] b_ie_reg;
reg [7:0] b_ie_next;
reg [7:0] c_oe_reg;
reg [7:0] c_oe_next;
reg [7:0] c_data_reg;
reg [7:0] c_data_next;
reg [7:0] c_read_view;
reg [7:0] rd_byte;
reg [31:0] hrdata_next;

// synchronised pin levels
wire [A_W-1:0] a_sync;
wire [B_W-1:0] b_sync;
wire [C_W-1:0] c_sync;

// data-phase write strobes
wire wr_a_ie;
wire wr_b_ie;
wire wr_c_oe;
wire wr_c_data;
integer k;

// pins come from outside the clock domain, so each port is synchronised
ppde_pin_sync #(
    .WIDTH(A_W)
) u_sync_a (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .pin_async(first_port_pin_in),
    .level_reg(a_sync)
);

ppde_pin_sync #(
    .WIDTH(B_W)
) u_sync_b (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .pin_async(second_port_pin_in),
    .level_reg(b_sync)
);

ppde_pin_sync #(
    .WIDTH(C_W)
) u_sync_c (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .pin_async(third_port_pin_in),
    .level_reg(c_sync)
);

// a transfer is taken only with the bus ready and the block clocked
assign ap_take = hsel & htrans[`PPDE_HTRANS_NONSEQ_BIT] & hready & ce;
assign ap_idx = haddr[`PPDE_IDX_MSB:`PPDE_IDX_LSB];
assign ap_in_range = (haddr[31:`PPDE_IDX_MSB+1] == 14'h0000);

// decode the word index; anything unmapped reads zero and drops writes
always @*
begin
    ap_sel = SEL_NONE;
    if (ap_in_range)
    begin
        case (ap_idx)
            `PPDE_IDX_A_IE: ap_sel = SEL_A_IE;
            `PPDE_IDX_B_IE: ap_sel = SEL_B_IE;
            `PPDE_IDX_C_OE: ap_sel = SEL_C_OE;
            `PPDE_IDX_C_DATA: ap_sel = SEL_C_DATA;
            `PPDE_IDX_A_LEVEL: ap_sel = SEL_A_LEVEL;
            `PPDE_IDX_B_LEVEL: ap_sel = SEL_B_LEVEL;
            default: ap_sel = SEL_NONE;
        endcase
    end
end

// remember the address phase for the write data that follows
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        dp_sel_reg <= SEL_NONE;
        dp_write_reg <= 1'b0;
    end
    else if (ce)
    begin
        if (ap_take)
        begin
            dp_sel_reg <= ap_sel;
            dp_write_reg <= hwrite;
        end
        else if (hready)
        begin
            dp_sel_reg <= SEL_NONE;
            dp_write_reg <= 1'b0;
        end
    end
end

// writes land at the end of the data phase, when hwdata stands
assign wr_a_ie = ce & dp_write_reg & dp_sel_reg[1];
assign wr_b_ie = ce & dp_write_reg & dp_sel_reg[2];
assign wr_c_oe = ce & dp_write_reg & dp_sel_reg[3];
assign wr_c_data = ce & dp_write_reg & dp_sel_reg[4];

// next values: masked writes, otherwise hold
always @*
begin
    a_ie_next = a_ie_reg;
    b_ie_next = b_ie_reg;
    c_oe_next = c_oe_reg;
    c_data_next = c_data_reg;
    if (wr_a_ie)
        a_ie_next = hwdata[7:0] & `PPDE_A_IE_MASK;
    if (wr_b_ie)
        b_ie_next = hwdata[7:0] & `PPDE_B_IE_MASK;
    if (wr_c_oe)
        c_oe_next = hwdata[7:0] & `PPDE_C_OE_MASK;
    if (wr_c_data)
        c_data_next = hwdata[7:0] & `PPDE_C_OE_MASK;
end

// enable registers; reset leaves all inputs and drivers off
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        a_ie_reg <= `PPDE_RST_BYTE;
        b_ie_reg <= `PPDE_RST_BYTE;
        c_oe_reg <= `PPDE_RST_BYTE;
        c_data_reg <= `PPDE_RST_BYTE;
    end
    else if (ce)
    begin
        a_ie_reg <= a_ie_next;
        b_ie_reg <= b_ie_next;
        c_oe_reg <= c_oe_next;
        c_data_reg <= c_data_next;
    end
end

// data read view: written value where driving, pin level elsewhere
always @*
begin
    c_read_view = `PPDE_RST_BYTE;
    for (k = 0; k < C_W; k = k + 1)
    begin
        if (c_oe_next[k])
            c_read_view[k] = c_data_next[k];
        else
            c_read_view[k] = c_sync[k];
    end
end

// read mux uses next values so a read right after a write sees it
always @*
begin
    rd_byte = `PPDE_RST_BYTE;
    case (ap_sel)
        SEL_A_IE: rd_byte = a_ie_next;
        SEL_B_IE: rd_byte = b_ie_next;
        SEL_C_OE: rd_byte = c_oe_next;
        SEL_C_DATA: rd_byte = c_read_view;
        SEL_A_LEVEL: rd_byte[A_W-1:0] = a_sync & a_ie_next[A_W-1:0];
        SEL_B_LEVEL: rd_byte[B_W-1:0] = b_sync & b_ie_next[B_W-1:0];
        SEL_NONE: rd_byte = `PPDE_RST_BYTE;
        default: rd_byte = `PPDE_RST_BYTE;
    endcase
    hrdata_next = {24'h000000, rd_byte};
end

// bus handshake: zero wait states and an okay answer on every transfer
// the block never stalls, so a master sees each data phase close in one cycle
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        hreadyout <= 1'b1;
        hresp <= `PPDE_HRESP_OKAY;
    end
    else if (ce)
    begin
        hreadyout <= 1'b1;
        hresp <= `PPDE_HRESP_OKAY;
    end
end

// read data loads at the address edge and stands until the next read
// loading only on reads keeps a write's data phase from disturbing it
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        hrdata <= `PPDE_RST_WORD;
    end
    else if (ap_take && !hwrite)
    begin
        hrdata <= hrdata_next;
    end
end

// first-port input path enables move at the same edge as the register
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        first_port_input_enable <= {A_W{1'b0}};
    end
    else if (ce)
    begin
        first_port_input_enable <= a_ie_next[A_W-1:0];
    end
end

// second-port input path enables, same timing as the first port
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        second_port_input_enable <= {B_W{1'b0}};
    end
    else if (ce)
    begin
        second_port_input_enable <= b_ie_next[B_W-1:0];
    end
end

// third-port pad controls mirror the next values so they move with the write
// oe_n comes from its own flop so the pad never sees a decode glitch
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        third_port_drive_enable <= {C_W{1'b0}};
        third_port_pin_oe_n <= {C_W{1'b1}};
        third_port_pin_out <= {C_W{1'b0}};
    end
    else if (ce)
    begin
        third_port_drive_enable <= c_oe_next[C_W-1:0];
        third_port_pin_oe_n <= ~c_oe_next[C_W-1:0];
        third_port_pin_out <= c_data_next[C_W-1:0];
    end
end

// first-port internal level: a disabled input path reads as zero
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        first_port_level <= {A_W{1'b0}};
    end
    else if (ce)
    begin
        first_port_level <= a_sync & a_ie_reg[A_W-1:0];
    end
end

// second-port internal level: a disabled input path reads as zero
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        second_port_level <= {B_W{1'b0}};
    end
    else if (ce)
    begin
        second_port_level <= b_sync & b_ie_reg[B_W-1:0];
    end
end

// third-port level has no input gate here, so it always shows the pad
// a driven pin therefore reads back its own output value
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        third_port_level <= {C_W{1'b0}};
    end
    else if (ce)
    begin
        third_port_level <= c_sync;
    end
end

endmodule

// ### verif/ppde_top_assertions.sv
// assertions for the port pin direction enable bank
`timescale 1ns/1ns
`include "ppde_consts.vh"
module ppde_check (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // register bus
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    // enables and levels
    input wire [7:0] first_port_input_enable,
    input wire [7:0] second_port_input_enable,
    input wire [3:0] third_port_drive_enable,
    input wire [3:0] third_port_pin_oe_n,
    input wire [7:0] first_port_level
);
    localparam [31:0] A_ADR = {14'h0, `PPDE_IDX_A_IE, 2'h0};
    localparam [31:0] B_ADR = {14'h0, `PPDE_IDX_B_IE, 2'h0};
    localparam [31:0] C_ADR = {14'h0, `PPDE_IDX_C_OE, 2'h0};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // write taken at the address edge; the register shows it two edges later
    sequence wr_s(logic [31:0] a);
        hsel && htrans[1] && hready && ce && hwrite && haddr == a;
    endsequence
    wire wa = hsel && htrans[1] && hready && ce && hwrite && haddr == A_ADR;
    wire [7:0] a_off = ~first_port_input_enable;
    oe_inverse_a: assert property (third_port_pin_oe_n == ~third_port_drive_enable)
        else $error("pad enable disagrees with drive enable");
    a_reserved_a: assert property ((first_port_input_enable & ~`PPDE_A_IE_MASK) == 8'h0)
        else $error("reserved first-port enable bit set");
    rd_high_a: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_write_a: assert property (wr_s(A_ADR) |-> ##2 first_port_input_enable == ($past(hwdata[7:0]) & 8'h2f))
        else $error("first-port enables miss the write");
    b_write_a: assert property (wr_s(B_ADR) |-> ##2 second_port_input_enable == $past(hwdata[7:0]))
        else $error("second-port enables miss the write");
    c_write_a: assert property (wr_s(C_ADR) |-> ##2 third_port_drive_enable == $past(hwdata[3:0]))
        else $error("drive enables miss the write");
    a_hold_a: assert property ($changed(first_port_input_enable) |-> $past(wa, 2))
        else $error("first-port enables changed with no write");
    // a disabled input may lag by the pipeline, so look back two samples
    a_level_a: assert property ((first_port_level & a_off & $past(a_off) & $past(a_off, 2)) == 8'h0)
        else $error("level seen on a disabled input");
endmodule

bind ppde_top ppde_check chk (.*);

// ### verif/ppde_top_test.sv
// self-checking bench for the port pin direction enable bank
`timescale 1ns/1ns
`include "ppde_consts.vh"
module ppde_top_test;
    localparam [31:0] A = {14'h0, `PPDE_IDX_A_IE, 2'h0};
    localparam [31:0] B = {14'h0, `PPDE_IDX_B_IE, 2'h0};
    localparam [31:0] C = {14'h0, `PPDE_IDX_C_OE, 2'h0};
    localparam [31:0] D = {14'h0, `PPDE_IDX_C_DATA, 2'h0};
    localparam [31:0] E = {14'h0, `PPDE_IDX_A_LEVEL, 2'h0};
    localparam [31:0] F = {14'h0, `PPDE_IDX_B_LEVEL, 2'h0};
    localparam [31:0] U = 32'hc2ec;
    reg clk_sys = 1'h0;
    reg resetn = 1'h0;
    reg ce = 1'h1;
    reg hsel = 1'h0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'h0;
    reg [31:0] hwdata = 32'h0;
    reg [7:0] a_pin = 8'h0;
    reg [7:0] b_pin = 8'h0;
    reg [3:0] c_ext = 4'h0;
    reg rd_dp = 1'h0;
    wire hreadyout, hresp;
    wire [31:0] hrdata;
    wire [7:0] a_en, a_lvl, b_en, b_lvl;
    wire [3:0] c_out, c_oe_n, c_de, c_lvl, c_pin;
    integer fails = 0;
    integer tests_run = 0;
    integer seed = 32'h3f24;
    integer i;
    logic [31:0] v, p;
    logic [3:0] m;
    logic [31:0] q[$];
    // a driven pad shows its own value, otherwise the outside level
    assign c_pin = (~c_oe_n & c_out) | (c_oe_n & c_ext);
    always #2 clk_sys = ~clk_sys;
    ppde_top dut (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .first_port_pin_in(a_pin),
        .first_port_input_enable(a_en), .first_port_level(a_lvl), .second_port_pin_in(b_pin),
        .second_port_input_enable(b_en), .second_port_level(b_lvl), .third_port_pin_in(c_pin),
        .third_port_pin_out(c_out), .third_port_pin_oe_n(c_oe_n), .third_port_drive_enable(c_de),
        .third_port_level(c_lvl)
    );
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task check(input string n, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // bounded wait for ready; a hang ends the run as a mismatch
    task rdy;
        integer n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'h1 && n < 16);
        if (n >= 16)
        begin
            fails++;
            conclude;
        end
    endtask
    // one single transfer: address phase, then data phase
    task bus(input logic w, input logic [31:0] a, d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        rdy;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
    endtask
    task rd(input logic [31:0] a, e);
        q.push_back(e);
        bus(1'h0, a, 32'h0);
    endtask
    // oldest note is compared when a read's data phase closes
    always @(posedge clk_sys)
    begin
        if (rd_dp)
            check("hrdata", hrdata, q.pop_front());
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
    end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'h1;
        check("pad oe_n", c_oe_n, 32'hf);
        check("drive enable", c_de, 32'h0);
        rd(A, 32'h0);
        rd(B, 32'h0);
        rd(C, 32'h0);
        // all ones to the A, B and C enables and the unmapped slot
        for (i = 0; i < 4; i++)
            bus(1'h1, i == 0 ? A : i == 1 ? B : i == 2 ? C : U, 32'hffffffff);
        rd(A, 32'h2f);
        rd(B, 32'hff);
        rd(C, 32'hf);
        rd(U, 32'h0);
        check("hresp", hresp, 32'h0);
        check("pad oe_n", c_oe_n, 32'h0);
        // random enables, data and pin levels
        for (i = 0; i < 6; i++)
        begin
            v = $random(seed);
            p = $random(seed);
            a_pin <= p[7:0];
            b_pin <= p[15:8];
            c_ext <= p[19:16];
            bus(1'h1, A, v);
            bus(1'h1, B, v >> 8);
            bus(1'h1, C, v >> 16);
            bus(1'h1, D, v >> 24);
            repeat (8) @(posedge clk_sys);
            check("first level", a_lvl, p[7:0] & v[7:0] & 8'h2f);
            check("second level", b_lvl, p[15:8] & v[15:8]);
            m = ~v[19:16];
            check("pad oe_n", c_oe_n, m);
            check("pin out", c_out, v[27:24]);
            check("first enable", a_en, v[7:0] & 8'h2f);
            check("second enable", b_en, v[15:8]);
            check("drive enable", c_de, v[19:16]);
            rd(A, v[7:0] & 8'h2f);
            rd(B, v[15:8]);
            rd(E, p[7:0] & v[7:0] & 8'h2f);
            rd(F, p[15:8] & v[15:8]);
            m = (v[19:16] & v[27:24]) | (~v[19:16] & p[19:16]);
            check("third level", c_lvl, m);
            rd(D, m);
        end
        // reset in mid-run clears every enable
        // held over several edges so no checker mistakes the clear for a write
        resetn <= 1'h0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'h1;
        check("first enable", a_en, 32'h0);
        check("second enable", b_en, 32'h0);
        check("pad oe_n", c_oe_n, 32'hf);
        rd(B, 32'h0);
        // let the watcher take the last note before closing
        repeat (2) @(posedge clk_sys);
        check("notes left", q.size(), 32'h0);
        conclude;
    end
endmodule
